// ==== pkg/pposr_regs.svh ====
/*
  register selects, field positions, reset values and function codes of the per-port
  status and converter result bank. assumes a 4-bit register select and 8-bit data.
*/
`ifndef PPOSR_REGS_SVH
`define PPOSR_REGS_SVH

`define PPOSR_SEL_CTRL1 4'h2
`define PPOSR_SEL_CTRL2 4'h3
`define PPOSR_SEL_STAT1 4'h4
`define PPOSR_SEL_STAT2 4'h5
`define PPOSR_SEL_DLO 4'h6
`define PPOSR_SEL_DHI 4'h7
`define PPOSR_SEL_VLO 4'h8
`define PPOSR_SEL_VHI 4'h9

`define PPOSR_C2_DIS_BIT 4
`define PPOSR_C2_START_BIT 3
`define PPOSR_C2_ABORT_BIT 2
`define PPOSR_S2_BUSY_BIT 3
`define PPOSR_CMPL_BIT 7

`define PPOSR_FN_OFF 4'h0
`define PPOSR_FN_DISC1 4'h1
`define PPOSR_FN_DISC2 4'h2

`define PPOSR_RST_BYTE 8'h00
`define PPOSR_RST_RESULT 15'h0000

`endif

// ==== pkg/pposr_pkg.sv ====
/*
  types of the per-port status and converter result bank.
  assumes nothing beyond a SystemVerilog compiler.
*/
package pposr_pkg;

  typedef enum logic [1:0] {
    PPOSR_KIND_DISC,
    PPOSR_KIND_VOLT,
    PPOSR_KIND_OTHER
  } pposr_conv_kind_t;

  typedef enum logic {
    PPOSR_ADC_IDLE,
    PPOSR_ADC_BUSY
  } pposr_adc_state_t;

  typedef struct packed {
    logic disc_fail;
    logic done;
    logic [2:0] cls;
    logic [2:0] fault;
  } pposr_status1_t;

endpackage : pposr_pkg

// ==== pkg/pposr_adc_if.sv ====
/*
  per-port handshake between the register bank and its converter tracker.
  assumes one instance per port, all on clk_sys_i.
*/
`timescale 1ns/1ps
interface pposr_adc_if;
  logic start;
  logic abort;
  logic halt;
  logic begin_ev;
  logic done_ev;
  logic busy;

  modport ctl (input start, input abort, input halt, input begin_ev, input done_ev, output busy);
  modport bank (output start, output abort, output halt, output begin_ev, output done_ev, input busy);
endinterface : pposr_adc_if

// ==== verilog/pposr_adc_ctl.sv ====
/*
  tracks whether one port's converter is converting.
  assumes start, begin_ev and done_ev are one-cycle pulses, abort and halt are levels or pulses.
*/
`timescale 1ns/1ps
module pposr_adc_ctl (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  pposr_adc_if.ctl adc
);

  pposr_pkg::pposr_adc_state_t state_r;
  pposr_pkg::pposr_adc_state_t state_nxt;
  wire logic stop_w = adc.abort | adc.halt;

  ////////////////////////////////////////////////////////////////////////////////
  // abort held high keeps the converter idle, so a start under abort is dropped
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      pposr_pkg::PPOSR_ADC_IDLE: begin
        if (!stop_w && (adc.start || adc.begin_ev)) begin
          state_nxt = pposr_pkg::PPOSR_ADC_BUSY; // see [RULE2]
        end
      end
      pposr_pkg::PPOSR_ADC_BUSY: begin
        if (stop_w || adc.done_ev) begin
          state_nxt = pposr_pkg::PPOSR_ADC_IDLE; // see [RULE3]
        end
      end
      default: state_nxt = pposr_pkg::PPOSR_ADC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= pposr_pkg::PPOSR_ADC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign adc.busy = (state_r == pposr_pkg::PPOSR_ADC_BUSY); // see [RULE8]

  ////////////////////////////////////////////////////////////////////////////////
  a_busy_on_start: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RULE8]
    (!adc.busy && adc.start && !stop_w) |=> adc.busy)
    else $error("converter not busy after start");

  a_abort_idles: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RULE3]
    adc.abort |=> !adc.busy)
    else $error("converter busy after abort");

endmodule : pposr_adc_ctl

// ==== verilog/pposr_result_reg.sv ====
/*
  one 15-bit converter result with its completion flag.
  assumes clr_i marks the start of a measurement and load_i its end.
*/
`timescale 1ns/1ps
module pposr_result_reg #(
  parameter int W = 15
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic wipe_i,
  input wire logic clr_i,
  input wire logic load_i,
  input wire logic [W-1:0] data_i,
  output logic [W-1:0] value_o,
  output logic cmpl_o
);

  logic [W-1:0] value_r;
  logic cmpl_r;
  wire logic [W-1:0] value_nxt = load_i ? data_i : (wipe_i ? '0 : value_r);
  // completion wins over a clear in the same cycle, so no finished result is hidden
  wire logic cmpl_nxt = load_i | (cmpl_r & ~clr_i & ~wipe_i);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      value_r <= '0;
      cmpl_r <= 1'b0;
    end else begin
      value_r <= value_nxt;
      cmpl_r <= cmpl_nxt;
    end
  end

  assign value_o = value_r;
  assign cmpl_o = cmpl_r;

  a_cmpl_cleared: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RULE12]
    (clr_i && !load_i) |=> !cmpl_o)
    else $error("completion flag not cleared at measurement start");

  a_cmpl_loaded: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RULE15]
    load_i |=> (cmpl_o && value_o == $past(data_i)))
    else $error("result not captured at completion");

endmodule : pposr_result_reg

// ==== verilog/pposr_bank.sv ====
/*
  per-port control, status and converter result registers of a quad power-sourcing manager.
  assumes a serial-bus front end that hands over one decoded register access per cycle
  (port, register select, data) and analog logic that reports status and results.
*/
`timescale 1ns/1ps
`include "pposr_regs.svh"

// Operation
// [RULE1] control bit 4 disables the port
// [RULE2] control bit 3 starts conversion, self-clearing
// [RULE3] control bit 2 aborts converter operation
// [RULE4] status bit 7 flags discovery failure
// [RULE5] done bit set, cleared by function write
// [RULE6] status bits 5..3 give power class
// [RULE7] status bits 2..0 give fault code
// [RULE8] status2 bit 3 shows conversion in progress
// [RULE9] status2 bits 2..0 give port state
// [RULE10] select 0110 reads result bits 7..0
// [RULE11] select 0111 reads result bits 14..8
// [RULE12] discovery start clears, completion sets bit 7
// [RULE13] select 1000 reads voltage bits 7..0
// [RULE14] function field; 0000 resets port functions
// [RULE15] select 1001 voltage high plus completion
// [RULE16] every register replicated, port selects copy
// [RULE17] unused bits read zero; reset clears all
module pposr_bank #(
  parameter int NP = 4,
  parameter int RW = 15
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [$clog2(NP)-1:0] reg_port_i,
  input wire logic [3:0] reg_sel_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic [NP-1:0] disc_fail_i,
  input wire logic [NP-1:0] func_done_i,
  input wire logic [NP-1:0][2:0] class_i,
  input wire logic [NP-1:0][2:0] fault_i,
  input wire logic [NP-1:0][2:0] func_state_i,
  input wire logic [NP-1:0] conv_begin_i,
  input wire logic [NP-1:0] conv_done_i,
  input wire logic [NP-1:0][1:0] conv_kind_i,
  input wire logic [NP-1:0][RW-1:0] conv_data_i,
  output logic [NP-1:0] port_disable_o,
  output logic [NP-1:0] adc_start_o,
  output logic [NP-1:0] adc_abort_o,
  output logic [NP-1:0][3:0] func_cmd_o,
  output logic [NP-1:0] func_wr_o
);

  localparam int PW = $clog2(NP);

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] pposr_hi_byte(input logic cmpl, input logic [RW-1:0] val);
    pposr_hi_byte = {cmpl, val[RW-1:8]};
  endfunction : pposr_hi_byte

  function automatic logic pposr_kind_is(input logic [1:0] kind, input pposr_pkg::pposr_conv_kind_t want);
    pposr_kind_is = (pposr_pkg::pposr_conv_kind_t'(kind) == want);
  endfunction : pposr_kind_is

  ////////////////////////////////////////////////////////////////////////////////
  logic [NP-1:0][3:0] fn_r;
  logic [NP-1:0] dis_r;
  logic [NP-1:0] start_r;
  logic [NP-1:0] abort_r;
  logic [NP-1:0] fn_wr_r;
  pposr_pkg::pposr_status1_t [NP-1:0] st1_r;
  logic [NP-1:0][2:0] state_r;
  logic [7:0] rdata_r;
  logic rvalid_r;

  wire logic [NP-1:0][7:0] rd_word;
  wire logic [NP-1:0] busy_w;
  wire logic [NP-1:0][RW-1:0] dval_w;
  wire logic [NP-1:0][RW-1:0] vval_w;
  wire logic [NP-1:0] dcmpl_w;
  wire logic [NP-1:0] vcmpl_w;

  ////////////////////////////////////////////////////////////////////////////////
  // one copy of every register per port; the access port index picks the copy
  for (genvar p = 0; p < NP; p++) begin : g_port // see [RULE16]
    wire logic hit = (reg_port_i == PW'(p));
    wire logic wr_c1 = reg_wr_i && hit && (reg_sel_i == `PPOSR_SEL_CTRL1);
    wire logic wr_c2 = reg_wr_i && hit && (reg_sel_i == `PPOSR_SEL_CTRL2);
    wire logic fn_off = wr_c1 && (reg_wdata_i[3:0] == `PPOSR_FN_OFF); // see [RULE14]
    wire logic disc_wr = wr_c1 && ((reg_wdata_i[3:0] == `PPOSR_FN_DISC1) ||
                                   (reg_wdata_i[3:0] == `PPOSR_FN_DISC2));
    wire logic is_disc_b = pposr_kind_is(conv_kind_i[p], pposr_pkg::PPOSR_KIND_DISC);
    wire logic is_volt_b = pposr_kind_is(conv_kind_i[p], pposr_pkg::PPOSR_KIND_VOLT);
    wire logic disc_clr = disc_wr || (conv_begin_i[p] && is_disc_b); // see [RULE12]
    wire logic disc_done = conv_done_i[p] && is_disc_b;
    wire logic volt_clr = conv_begin_i[p] && is_volt_b; // see [RULE15]
    wire logic volt_done = conv_done_i[p] && is_volt_b;
    // a finished function in the same cycle as a new command still shows as done
    wire logic done_nxt = func_done_i[p] | (st1_r[p].done & ~wr_c1); // see [RULE5]
    pposr_adc_if adc ();

    assign adc.start = start_r[p];
    assign adc.abort = abort_r[p];
    assign adc.halt = fn_off;
    assign adc.begin_ev = conv_begin_i[p];
    assign adc.done_ev = conv_done_i[p];
    assign busy_w[p] = adc.busy;

    pposr_adc_ctl u_adc (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .adc(adc)
    );

    pposr_result_reg #(.W(RW)) u_disc (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .wipe_i(fn_off),
      .clr_i(disc_clr),
      .load_i(disc_done),
      .data_i(conv_data_i[p]),
      .value_o(dval_w[p]),
      .cmpl_o(dcmpl_w[p])
    );

    pposr_result_reg #(.W(RW)) u_volt (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .wipe_i(fn_off),
      .clr_i(volt_clr),
      .load_i(volt_done),
      .data_i(conv_data_i[p]),
      .value_o(vval_w[p]),
      .cmpl_o(vcmpl_w[p])
    );

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        fn_r[p] <= `PPOSR_FN_OFF;
        fn_wr_r[p] <= 1'b0;
      end else begin
        fn_wr_r[p] <= wr_c1;
        if (wr_c1) begin
          fn_r[p] <= reg_wdata_i[3:0]; // see [RULE14]
        end
      end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        dis_r[p] <= 1'b0;
        abort_r[p] <= 1'b0;
        start_r[p] <= 1'b0;
      end else begin
        // start lives one cycle only, so only a read issued in the cycle right after the write sees it set
        start_r[p] <= wr_c2 && reg_wdata_i[`PPOSR_C2_START_BIT]; // see [RULE2]
        if (wr_c2) begin
          dis_r[p] <= reg_wdata_i[`PPOSR_C2_DIS_BIT]; // see [RULE1]
          abort_r[p] <= reg_wdata_i[`PPOSR_C2_ABORT_BIT]; // see [RULE3]
        end
      end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        st1_r[p] <= '0;
        state_r[p] <= 3'h0;
      end else begin
        st1_r[p].disc_fail <= disc_fail_i[p]; // see [RULE4]
        st1_r[p].done <= done_nxt; // see [RULE5]
        st1_r[p].cls <= class_i[p]; // see [RULE6]
        st1_r[p].fault <= fault_i[p]; // see [RULE7]
        state_r[p] <= func_state_i[p]; // see [RULE9]
      end
    end

    // unmapped selects and unused bits give zero
    assign rd_word[p] =
      (reg_sel_i == `PPOSR_SEL_CTRL1) ? {4'h0, fn_r[p]} :
      (reg_sel_i == `PPOSR_SEL_CTRL2) ? {3'h0, dis_r[p], start_r[p], abort_r[p], 2'h0} : // see [RULE17]
      (reg_sel_i == `PPOSR_SEL_STAT1) ? st1_r[p] :
      (reg_sel_i == `PPOSR_SEL_STAT2) ? {4'h0, busy_w[p], state_r[p]} : // see [RULE8]
      (reg_sel_i == `PPOSR_SEL_DLO) ? dval_w[p][7:0] : // see [RULE10]
      (reg_sel_i == `PPOSR_SEL_DHI) ? pposr_hi_byte(dcmpl_w[p], dval_w[p]) : // see [RULE11]
      (reg_sel_i == `PPOSR_SEL_VLO) ? vval_w[p][7:0] : // see [RULE13]
      (reg_sel_i == `PPOSR_SEL_VHI) ? pposr_hi_byte(vcmpl_w[p], vval_w[p]) : // see [RULE15]
      `PPOSR_RST_BYTE;

    //////////////////////////////////////////////////////////////////////////////
    a_disable_bit: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RULE1]
      wr_c2 |=> (port_disable_o[p] == $past(reg_wdata_i[`PPOSR_C2_DIS_BIT])))
      else $error("port disable does not follow the written bit");

    a_start_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RULE2]
      // a second start write right behind the first legally keeps the pulse up
      (wr_c2 && reg_wdata_i[`PPOSR_C2_START_BIT]) |=> adc_start_o[p] ##1
        (!adc_start_o[p] || $past(wr_c2 && reg_wdata_i[`PPOSR_C2_START_BIT])))
      else $error("converter start is not a single self-clearing pulse");

    a_abort_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RULE3]
      (wr_c2 && reg_wdata_i[`PPOSR_C2_ABORT_BIT]) |=> adc_abort_o[p] ##1 !busy_w[p])
      else $error("abort did not stop the converter");

    a_disc_fail: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RULE4]
      ##1 (st1_r[p].disc_fail == $past(disc_fail_i[p])))
      else $error("discovery failure bit stale");

    a_done_cleared: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RULE5]
      (wr_c1 && !func_done_i[p]) |=> !st1_r[p].done)
      else $error("done bit survived a new function command");

    a_done_sticky: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RULE5]
      func_done_i[p] |=> st1_r[p].done until_with (wr_c1 && !func_done_i[p]))
      else $error("done bit lost before a new function command");

    a_class_fault: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RULE7]
      $changed(fault_i[p]) or $changed(class_i[p]) |=> (st1_r[p].fault == $past(fault_i[p]) &&
                                                        st1_r[p].cls == $past(class_i[p])))
      else $error("class or fault code not reported");

    a_state_code: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RULE9]
      $changed(func_state_i[p]) |=> (state_r[p] == $past(func_state_i[p])))
      else $error("port state not reported");

    a_off_wipes: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RULE14]
      (fn_off && !conv_done_i[p]) |=> (dval_w[p] == `PPOSR_RST_RESULT && !busy_w[p] && !dcmpl_w[p]))
      else $error("function 0000 did not reset the port");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read data is registered: one cycle of latency buys outputs straight from flops
  wire logic [7:0] rdata_nxt = reg_rd_i ? rd_word[reg_port_i] : `PPOSR_RST_BYTE;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= `PPOSR_RST_BYTE; // see [RULE17]
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= reg_rd_i;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign reg_rvalid_o = rvalid_r;
  assign port_disable_o = dis_r;
  assign adc_start_o = start_r;
  assign adc_abort_o = abort_r;
  assign func_cmd_o = fn_r;
  assign func_wr_o = fn_wr_r;

  a_read_dlo: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RULE10]
    (reg_rd_i && reg_sel_i == `PPOSR_SEL_DLO) |=> reg_rvalid_o && reg_rdata_o == $past(dval_w[reg_port_i][7:0]))
    else $error("discovery low byte read wrong");

  a_read_dhi: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RULE11]
    (reg_rd_i && reg_sel_i == `PPOSR_SEL_DHI) |=> reg_rdata_o[6:0] == $past(dval_w[reg_port_i][14:8]))
    else $error("discovery high byte read wrong");

  a_read_unmapped: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RULE17]
    (reg_rd_i && (reg_sel_i < `PPOSR_SEL_CTRL1 || reg_sel_i > `PPOSR_SEL_VHI)) |=> reg_rdata_o == 8'h00)
    else $error("unmapped select did not read zero");

endmodule : pposr_bank

// ==== dv/pposr_afe_model.sv ====
/*
  analog front-end stand-in for the per-port bank: answers each converter start made without abort with a begin
  pulse and, DLY cycles later unless aborted first, a done pulse carrying the result the bench asked for.
  assumes the bank's outputs change just after rising edges of clk_sys_i.
*/
`timescale 1ns/1ps
module pposr_afe_model #(
  parameter int DLY = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [3:0] adc_start_i,
  input wire logic [3:0] adc_abort_i,
  input wire logic [1:0] kind_i,
  input wire logic [14:0] data_i,
  output logic [3:0] conv_begin_o,
  output logic [3:0] conv_done_o,
  output logic [3:0][1:0] conv_kind_o,
  output logic [3:0][14:0] conv_data_o
);
  int cnt [4];
  ////////////////////////////////////////////////////////////////////////////////
  // result lines carry the inverse outside the done cycle so a late sample shows up
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    for (int p = 0; p < 4; p++) begin
      if (!rst_n_i) begin
        cnt[p] <= 0;
        conv_begin_o[p] <= 1'b0;
        conv_done_o[p] <= 1'b0;
        conv_kind_o[p] <= 2'h0;
        conv_data_o[p] <= 15'h7FFF;
      end else begin
        conv_begin_o[p] <= adc_start_i[p] && !adc_abort_i[p];
        conv_done_o[p] <= (cnt[p] == 1) && !adc_abort_i[p];
        conv_kind_o[p] <= kind_i;
        conv_data_o[p] <= (cnt[p] == 1) ? data_i : ~data_i;
        if (adc_abort_i[p]) begin
          cnt[p] <= 0;
        end else if (adc_start_i[p]) begin
          cnt[p] <= DLY;
        end else if (cnt[p] > 0) begin
          cnt[p] <= cnt[p] - 1;
        end
      end
    end
  end
endmodule : pposr_afe_model

// ==== dv/testbench.sv ====
/*
  self-checking bench for the per-port status and result bank, driving its decoded register
  port and analog status inputs. assumes the afe model answers converter starts.
*/
`timescale 1ns/1ps
`include "pposr_regs.svh"
module testbench;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [1:0] reg_port_i = 2'h0;
  logic [3:0] reg_sel_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic reg_rvalid_o;
  logic [3:0] disc_fail_i = 4'h0;
  logic [3:0] func_done_i = 4'h0;
  logic [3:0][2:0] class_i = '0;
  logic [3:0][2:0] fault_i = '0;
  logic [3:0][2:0] func_state_i = '0;
  logic [3:0] conv_begin_i;
  logic [3:0] conv_done_i;
  logic [3:0][1:0] conv_kind_i;
  logic [3:0][14:0] conv_data_i;
  logic [3:0] port_disable_o;
  logic [3:0] adc_start_o;
  logic [3:0] adc_abort_o;
  logic [3:0] func_wr_o;
  logic [3:0][3:0] func_cmd_o;
  logic [1:0] kind = 2'h1;
  logic [14:0] res_val = 15'h0000;
  int errors = 0;
  int n_compared = 0;

  always #10 clk_sys_i = ~clk_sys_i;

  pposr_bank #(.NP(4), .RW(15)) pposr_bank_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_port_i(reg_port_i), .reg_sel_i(reg_sel_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .disc_fail_i(disc_fail_i), .func_done_i(func_done_i), .class_i(class_i), .fault_i(fault_i),
    .func_state_i(func_state_i), .conv_begin_i(conv_begin_i), .conv_done_i(conv_done_i),
    .conv_kind_i(conv_kind_i), .conv_data_i(conv_data_i), .port_disable_o(port_disable_o),
    .adc_start_o(adc_start_o), .adc_abort_o(adc_abort_o), .func_cmd_o(func_cmd_o), .func_wr_o(func_wr_o));

  pposr_afe_model #(.DLY(8)) pposr_afe_model_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .adc_start_i(adc_start_o), .adc_abort_i(adc_abort_o), .kind_i(kind), .data_i(res_val),
    .conv_begin_o(conv_begin_i), .conv_done_o(conv_done_i), .conv_kind_o(conv_kind_i),
    .conv_data_o(conv_data_i));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] seen);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check8

  // one-cycle strobe; returns just after the taking edge so pulse outputs can be looked at
  task automatic wr(input logic [1:0] p, input logic [3:0] s, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_port_i <= p;
    reg_sel_i <= s;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [1:0] p, input logic [3:0] s, input logic [7:0] exp, input string what,
                    input logic [7:0] mask = 8'hFF);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_port_i <= p;
    reg_sel_i <= s;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    check8({what, " valid"}, 8'h01, {7'h00, reg_rvalid_o});
    check8(what, exp & mask, reg_rdata_o & mask);
  endtask : rd

  task automatic wait_done(input int p);
    for (int i = 0; i < 40 && conv_done_i[p] !== 1'b1; i++) begin
      @(posedge clk_sys_i);
      #1;
    end
    if (conv_done_i[p] !== 1'b1) begin
      errors++;
      $display("Error conversion done expected 1 seen %b", conv_done_i[p]);
    end
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask : wait_done

  task automatic report_and_stop;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      for (int s = 0; s < 16; s++) rd(p[1:0], s[3:0], 8'h00, "reset value");
    end
    wr(2'h2, `PPOSR_SEL_CTRL2, 8'hF7);
    check8("disable out", 8'h04, {4'h0, port_disable_o});
    check8("abort out", 8'h04, {4'h0, adc_abort_o});
    rd(2'h2, `PPOSR_SEL_CTRL2, 8'h14, "ctrl2 readback");
    wr(2'h2, `PPOSR_SEL_CTRL2, 8'h00);
    check8("enable out", 8'h00, {port_disable_o, adc_abort_o});
    wr(2'h2, `PPOSR_SEL_CTRL1, 8'hF3);
    rd(2'h2, `PPOSR_SEL_CTRL1, 8'h03, "ctrl1 unused bits");
    wr(2'h1, 4'hA, 8'hFF);
    rd(2'h1, 4'hA, 8'h00, "unmapped select");
    // voltage conversion on port 1
    res_val <= 15'h5A3C;
    wr(2'h1, `PPOSR_SEL_CTRL2, 8'h08);
    check8("start pulse", 8'h02, {4'h0, adc_start_o});
    rd(2'h1, `PPOSR_SEL_CTRL2, 8'h00, "start self clear");
    rd(2'h1, `PPOSR_SEL_STAT2, 8'h08, "converter busy");
    rd(2'h1, `PPOSR_SEL_VHI, 8'h00, "volt active", 8'h80);
    wait_done(1);
    rd(2'h1, `PPOSR_SEL_STAT2, 8'h00, "converter idle");
    rd(2'h1, `PPOSR_SEL_VLO, 8'h3C, "volt low");
    rd(2'h1, `PPOSR_SEL_VHI, 8'hDA, "volt high");
    rd(2'h0, `PPOSR_SEL_VHI, 8'h00, "other port volt");
    // discovery conversion on port 3, then function writes
    kind <= 2'h0;
    res_val <= 15'h7FFF;
    wr(2'h3, `PPOSR_SEL_CTRL2, 8'h08);
    wait_done(3);
    rd(2'h3, `PPOSR_SEL_DLO, 8'hFF, "disc low");
    rd(2'h3, `PPOSR_SEL_DHI, 8'hFF, "disc high");
    wr(2'h3, `PPOSR_SEL_CTRL1, `PPOSR_FN_DISC1);
    check8("function strobe", 8'h08, {4'h0, func_wr_o});
    check8("function code", 8'h01, {4'h0, func_cmd_o[3]});
    rd(2'h3, `PPOSR_SEL_DHI, 8'h00, "disc complete clear", 8'h80);
    wr(2'h3, `PPOSR_SEL_CTRL1, `PPOSR_FN_OFF);
    rd(2'h3, `PPOSR_SEL_DLO, 8'h00, "off wipes low");
    rd(2'h3, `PPOSR_SEL_DHI, 8'h00, "off wipes high");
    rd(2'h1, `PPOSR_SEL_VHI, 8'hDA, "port 1 kept");
    // abort in mid-conversion; the model would finish after 8 cycles
    kind <= 2'h1;
    wr(2'h0, `PPOSR_SEL_CTRL2, 8'h08);
    wr(2'h0, `PPOSR_SEL_CTRL2, 8'h04);
    rd(2'h0, `PPOSR_SEL_STAT2, 8'h00, "abort idle");
    repeat (12) @(posedge clk_sys_i);
    rd(2'h0, `PPOSR_SEL_VHI, 8'h00, "aborted no result");
    // the start bit still pulses, but the held abort keeps the converter idle
    wr(2'h0, `PPOSR_SEL_CTRL2, 8'h0C);
    check8("start under abort", 8'h01, {4'h0, adc_start_o});
    rd(2'h0, `PPOSR_SEL_STAT2, 8'h00, "busy under abort");
    wr(2'h0, `PPOSR_SEL_CTRL2, 8'h00);
    // status fields, every code
    @(posedge clk_sys_i);
    func_done_i <= 4'hF;
    @(posedge clk_sys_i);
    func_done_i <= 4'h0;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys_i);
      disc_fail_i[i % 4] <= i[0];
      class_i[i % 4] <= i[2:0];
      fault_i[i % 4] <= 3'(7 - i);
      func_state_i[i % 4] <= i[2:0];
      rd(2'(i % 4), `PPOSR_SEL_STAT1, {i[0], 1'b1, i[2:0], 3'(7 - i)}, "status1");
      rd(2'(i % 4), `PPOSR_SEL_STAT2, {5'h00, i[2:0]}, "status2");
    end
    wr(2'h0, `PPOSR_SEL_CTRL1, 8'h05);
    rd(2'h0, `PPOSR_SEL_STAT1, 8'h00, "done cleared", 8'h40);
    rd(2'h1, `PPOSR_SEL_STAT1, 8'h40, "done kept", 8'h40);
    report_and_stop();
  end

  // whole run is about 280 cycles; a hang is cut after 20000
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    errors++;
    $display("Error watchdog expected finish seen hang");
    report_and_stop();
  end
endmodule : testbench
